// ---- logic/dcc_code_cal.sv ----
`timescale 1ns/1ps
// Operation
// RULE1: select bits route word to input/offset/gain/special
// RULE2: 32 channels, each with code, offset, gain
// RULE3: resolved = (gain+2)/2^14*code + offset-8192
// RULE4: gain resets to 0x3FFE, unity gain
// RULE5: host writes gain with bit0 zero
// RULE6: offset is offset binary, reset 0x2000
// RULE7: double buffered; load pin updates all together
// RULE8: control bits pick reference source and level
// RULE9: reset restores all registers, busy low 270us; a soft reset leaves specialData at its last value
// RULE10: busy low blocks writes and load pulses
// RULE11: resolved code saturates to 0..16383
module dcc_code_cal #(
    parameter int RESET_CNT = dcc_pkg::RESET_CYCLES
) (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      sys_rst,
    // host write port
    input  wire dcc_pkg::dcc_wr_t          wrIn,
    input  wire logic                      load_outputs_n,
    input  wire logic                      softReset_n,
    // control bits
    input  wire logic                      ref_source_select,
    input  wire logic                      ref_level_select,
    // status and outputs
    output logic                           busy_n,
    output logic                           specialStrobe,
    output logic [13:0]                    specialData,
    output logic                           useInternalRef,
    output logic                           refLevelHigh,
    output logic [dcc_pkg::NUM_CH*14-1:0]  resolved_code
);
    import dcc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // clamp a signed corrected code into the converter range
    function automatic logic [13:0] clamp_code(input logic signed [16:0] value);
        logic [13:0] clamped;
        if (value < 17'sh0) begin
            clamped = 14'h0000; // see RULE11
        end else if (value > signed'({3'h0, CODE_MAX})) begin
            clamped = CODE_MAX; // see RULE11
        end else begin
            clamped = value[13:0];
        end
        return clamped;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // reset sequencer
    logic [31:0] rstCnt_reg, rstCnt_next;
    logic        rstPrev_reg, rstPrev_next;
    logic        clearing;
    logic        hostOk;
    logic        softFall;
    logic        writeOk;

    always_comb begin
        rstPrev_next = softReset_n;
        rstCnt_next  = rstCnt_reg;
        // the pin is not watched while a sequence runs, so a second fall is lost
        softFall     = rstPrev_reg && !softReset_n && !clearing;
        if (softFall) begin
            rstCnt_next = RESET_CNT[31:0]; // see RULE9
        end else if (clearing) begin
            rstCnt_next = rstCnt_reg - 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rstCnt_reg  <= RESET_CNT[31:0]; // see RULE9
            rstPrev_reg <= 1'b1;
        end else begin
            rstCnt_reg  <= rstCnt_next;
            rstPrev_reg <= rstPrev_next;
        end
    end

    // busy is a level of the count, so it drops one edge after the trigger
    assign clearing = (rstCnt_reg != 32'h0);
    assign busy_n   = !clearing;
    assign hostOk   = !clearing; // see RULE10
    assign writeOk  = wrIn.strobe && hostOk; // see RULE10

    ////////////////////////////////////////////////////////////////////////
    // reference control
    // the level bit means nothing once the external reference is chosen
    always_comb begin
        useInternalRef = !ref_source_select;                  // see RULE8
        refLevelHigh   = !ref_source_select && ref_level_select; // see RULE8
    end

    ////////////////////////////////////////////////////////////////////////
    // special function pass-through
    dcc_sel_t sel;
    logic     spStb_reg, spStb_next;
    logic [13:0] spDat_reg, spDat_next;

    assign sel = dcc_sel_t'({wrIn.regSelectHi, wrIn.regSelectLo});

    // only strobed out; the special space is decoded outside this block
    always_comb begin
        spStb_next = writeOk && sel == DCC_SEL_SPECIAL; // see RULE1
        spDat_next = spStb_next ? wrIn.dataBusBits : spDat_reg;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            spStb_reg <= 1'b0;
            spDat_reg <= 14'h0000;
        end else begin
            spStb_reg <= spStb_next;
            spDat_reg <= spDat_next;
        end
    end

    assign specialStrobe = spStb_reg;
    assign specialData   = spDat_reg;

    ////////////////////////////////////////////////////////////////////////
    // per-channel registers and correction
    logic loadPrev_reg, loadPrev_next;
    logic loadFall;
    logic loadPulse;

    // edge detect: a pin held low transfers once, not on every clock
    always_comb begin
        loadPrev_next = load_outputs_n;
        loadFall      = loadPrev_reg && !load_outputs_n;
        loadPulse     = loadFall && hostOk; // see RULE10
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            loadPrev_reg <= 1'b1;
        end else begin
            loadPrev_reg <= loadPrev_next;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_ch // see RULE2
            logic [13:0] code_reg, code_next;
            logic [13:0] offs_reg, offs_next;
            logic [13:0] gain_reg, gain_next;
            logic [13:0] out_reg, out_next;
            logic        hit;
            logic [28:0] prod;
            logic signed [16:0] sum;

            // correction datapath; the zero-offset code is the midpoint
            always_comb begin
                prod = (29'(gain_reg) + 29'h2) * 29'(code_reg); // see RULE3
                sum  = signed'({3'h0, prod[27:14]})
                     + signed'({3'h0, offs_reg})
                     - signed'({3'h0, OFFSET_RESET}); // see RULE3
            end

            // input, offset and gain registers; writes during a sequence drop
            always_comb begin
                hit       = writeOk && wrIn.channel == CH_W'(ch);
                code_next = code_reg;
                offs_next = offs_reg;
                gain_next = gain_reg;
                if (clearing) begin
                    code_next = CODE_RESET;   // see RULE9
                    offs_next = OFFSET_RESET; // see RULE6
                    gain_next = GAIN_RESET;   // see RULE4
                end else if (hit) begin
                    case (sel) // see RULE1
                        DCC_SEL_INPUT: code_next = wrIn.dataBusBits;
                        DCC_SEL_OFFSET: offs_next = wrIn.dataBusBits;
                        // low bit forced to zero for a sloppy host
                        DCC_SEL_GAIN: gain_next = {wrIn.dataBusBits[13:1], 1'b0}; // see RULE5
                        default: ;
                    endcase
                end
            end

            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    code_reg <= CODE_RESET;
                    offs_reg <= OFFSET_RESET;
                    gain_reg <= GAIN_RESET;
                end else begin
                    code_reg <= code_next;
                    offs_reg <= offs_next;
                    gain_reg <= gain_next;
                end
            end

            // output buffer; a write on the load edge is not yet seen here
            always_comb begin
                out_next = out_reg;
                if (clearing) begin
                    out_next = CODE_RESET; // see RULE9
                end else if (loadPulse) begin
                    out_next = clamp_code(sum); // see RULE7 RULE11
                end
            end

            // double buffer: held until the next load edge or reset
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    out_reg <= CODE_RESET;
                end else begin
                    out_reg <= out_next;
                end
            end

            assign resolved_code[ch*14 +: 14] = out_reg;
        end
    endgenerate
endmodule

// ---- logic/dcc_pkg.sv ----
package dcc_pkg;
    localparam int          CODE_W       = 14;
    localparam int          NUM_CH       = 32;
    localparam int          CH_W         = 5;
    localparam logic [13:0] GAIN_RESET   = 14'h3FFE;
    localparam logic [13:0] OFFSET_RESET = 14'h2000;
    localparam logic [13:0] CODE_RESET   = 14'h0000;
    localparam logic [13:0] CODE_MAX     = 14'h3FFF;
    localparam int          RESET_TIME_US = 270;
    localparam int          CLK_MHZ      = 25;
    localparam int          RESET_CYCLES = RESET_TIME_US * CLK_MHZ;

    typedef enum logic [1:0] {
        DCC_SEL_SPECIAL = 2'b00,
        DCC_SEL_GAIN    = 2'b01,
        DCC_SEL_OFFSET  = 2'b10,
        DCC_SEL_INPUT   = 2'b11
    } dcc_sel_t;

    typedef struct packed {
        logic            strobe;
        logic [CH_W-1:0] channel;
        logic            regSelectHi;
        logic            regSelectLo;
        logic [13:0]     dataBusBits;
    } dcc_wr_t;
endpackage

// ---- verif/dcc_code_cal_asserts.sv ----
`timescale 1ns/1ps
module dcc_code_cal_asserts #(parameter int RESET_CNT = 20) (
    input wire logic clk, sys_rst, load_outputs_n, softReset_n,
    input wire dcc_pkg::dcc_wr_t wrIn,
    input wire logic ref_source_select, ref_level_select, busy_n, specialStrobe,
    input wire logic useInternalRef, refLevelHigh,
    input wire logic [13:0] specialData,
    input wire logic [dcc_pkg::NUM_CH*14-1:0] resolved_code
);
    import dcc_pkg::*;
    logic spWr;
    assign spWr = wrIn.strobe && busy_n && !wrIn.regSelectHi && !wrIn.regSelectLo;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    rst_clear_a: assert property (disable iff (1'b0) sys_rst |=> !busy_n && resolved_code == '0)
        else $error("reset did not clear outputs");
    int_ref_a: assert property (useInternalRef == !ref_source_select) else $error("ref source");
    ref_lvl_a: assert property (refLevelHigh == (ref_level_select && !ref_source_select))
        else $error("ref level");
    spec_pulse_a: assert property (spWr |=> specialStrobe && specialData == $past(wrIn.dataBusBits))
        else $error("special write lost");
    spec_quiet_a: assert property (!spWr |=> !specialStrobe) else $error("stray special strobe");
    out_hold_a: assert property (busy_n && !$fell(load_outputs_n) |=> !busy_n || $stable(resolved_code))
        else $error("outputs moved without load");
    busy_zero_a: assert property (!busy_n && !$past(busy_n) |-> resolved_code == '0)
        else $error("outputs not default while busy");
    soft_busy_a: assert property ($fell(softReset_n) && busy_n |=> !busy_n) else $error("no busy");
    cover property (spWr);
    cover property (busy_n && $fell(load_outputs_n));
    cover property ($rose(busy_n));
endmodule
bind dcc_code_cal dcc_code_cal_asserts #(.RESET_CNT(RESET_CNT)) dcc_code_cal_asserts_inst (.*);

// ---- verif/dcc_host_model.sv ----
`timescale 1ns/1ps
module dcc_host_model (
    input  wire logic        clk,
    output dcc_pkg::dcc_wr_t wrOut,
    output logic             loadN
);
    import dcc_pkg::*;
    initial begin
        wrOut = '0;
        loadN = 1'b1;
    end
    task automatic write(input logic [4:0] ch, input logic [1:0] sel, input logic [13:0] d);
        @(posedge clk);
        #1 wrOut = '{1'b1, ch, sel[1], sel[0], (sel == 2'h1) ? {d[13:1], 1'b0} : d};
        @(posedge clk);
        #1 wrOut = '{1'b0, ~ch, ~sel[1], ~sel[0], ~d};
    endtask
    task automatic pulse_load();
        @(posedge clk);
        #1 loadN = 1'b0;
        @(posedge clk);
        #1 loadN = 1'b1;
    endtask
endmodule

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    import dcc_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, softReset_n = 1'b1, refSrc = 1'b0, refLvl = 1'b0;
    logic busy_n, specialStrobe, useInternalRef, refLevelHigh, loadN;
    logic [13:0] specialData, code [32], off [32], gain [32];
    logic [NUM_CH*14-1:0] resolved_code;
    dcc_wr_t wrIn;
    int error_cnt = 0, checks_done = 0;
    always #20 clk = ~clk;
    dcc_host_model dcc_host_model_inst (.clk(clk), .wrOut(wrIn), .loadN(loadN));
    dcc_code_cal #(.RESET_CNT(20)) dcc_code_cal_inst (.clk(clk), .sys_rst(sys_rst),
        .wrIn(wrIn), .load_outputs_n(loadN), .softReset_n(softReset_n),
        .ref_source_select(refSrc), .ref_level_select(refLvl), .busy_n(busy_n),
        .specialStrobe(specialStrobe), .specialData(specialData), .useInternalRef(useInternalRef),
        .refLevelHigh(refLevelHigh), .resolved_code(resolved_code));
    function automatic logic [13:0] calc(input int i);
        int v;
        v = (((int'(gain[i]) + 2) * int'(code[i])) >>> 14) + int'(off[i]) - 8192;
        return (v < 0) ? 14'h0000 : (v > 16383) ? 14'h3FFF : v[13:0];
    endfunction
    task automatic chk(input logic [13:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic defaults();
        foreach (code[i]) {code[i], off[i], gain[i]} = {14'h0000, 14'h2000, 14'h3FFE};
    endtask
    task automatic wr(input logic [4:0] ch, input logic [1:0] sel, input logic [13:0] d);
        dcc_host_model_inst.write(ch, sel, d);
        if (sel == 2'h3) code[ch] = d;
        if (sel == 2'h2) off[ch] = d;
        if (sel == 2'h1) gain[ch] = {d[13:1], 1'b0};
    endtask
    task automatic wait_ready();
        for (int n = 0; n < 100 && busy_n !== 1'b1; n++) @(posedge clk) #1;
        chk({13'h0, busy_n}, 14'h0001);
    endtask
    task automatic load_check();
        dcc_host_model_inst.pulse_load();
        @(posedge clk) #1;
        for (int i = 0; i < NUM_CH; i++) chk(resolved_code[i*14+:14], calc(i));
    endtask
    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        void'($urandom(99));
        defaults();
        repeat (12) @(posedge clk);
        #1 sys_rst = 1'b0;
        wait_ready();
        load_check();
        $display("test reset_defaults done");
        wr(3, 2'h3, 14'h3FFF);
        wr(3, 2'h2, 14'h3FFF);
        wr(4, 2'h2, 14'h0000);
        wr(5, 2'h1, 14'h1FFF);
        wr(5, 2'h3, 14'h2000);
        wr(6, 2'h0, 14'h1234);
        chk(specialData, 14'h1234);
        chk({13'h0, specialStrobe}, 14'h0001);
        load_check();
        repeat (40) begin
            {refSrc, refLvl} = 2'($urandom);
            wr(5'($urandom), 2'($urandom), 14'($urandom));
            chk({13'h0, useInternalRef}, {13'h0, !refSrc});
            chk({13'h0, refLevelHigh}, {13'h0, !refSrc && refLvl});
            if ($urandom % 4 == 0) load_check();
        end
        $display("test random_codes done");
        softReset_n = 1'b0;
        defaults();
        // refused while busy, so the expected registers stay at defaults
        dcc_host_model_inst.write(1, 2'h3, 14'h0FFF);
        chk({13'h0, busy_n}, 14'h0000);
        dcc_host_model_inst.pulse_load();
        softReset_n = 1'b1;
        wait_ready();
        load_check();
        $display("test soft_reset done");
        report_and_stop();
    end
    initial begin
        #200000;
        error_cnt++;
        report_and_stop();
    end
endmodule
